// ---- hw/vic_defs.vh ----
// Register offsets, field layouts and reset values of the vectored interrupt controller.
// Assumes inclusion by bare name from the design files.
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VIC_OFF_NRM_STAT    12'h000
`define VIC_OFF_FST_STAT    12'h004
`define VIC_OFF_RAW_STAT    12'h008
`define VIC_OFF_CLASS_SEL   12'h00c
`define VIC_OFF_EN_SET      12'h010
`define VIC_OFF_EN_CLR      12'h014
`define VIC_OFF_SW_SET      12'h018
`define VIC_OFF_SW_CLR      12'h01c
`define VIC_OFF_PRIO_MASK   12'h024
`define VIC_OFF_CUR_VECT    12'h028
`define VIC_OFF_EVT_STAT    12'h02c
`define VIC_OFF_EVT_CLR     12'h030
`define VIC_OFF_EVT_EN      12'h034
`define VIC_OFF_VECT_BASE   12'h100
`define VIC_OFF_PRIO_BASE   12'h200
`define VIC_OFF_TABLE_END   12'h280

// ----------------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------------
`define VIC_PRIO_W          4
`define VIC_EVT_W           2
`define VIC_EVT_FST_BIT     0
`define VIC_EVT_NRM_BIT     1
`define VIC_RST_WORD        32'h00000000
`define VIC_RST_PRIO_MASK   16'hffff
`define VIC_RST_PRIO        4'hf

`endif

// ---- hw/vic_vect_mem.v ----
// Vector address table: one word per input channel, registered read port.
// Assumes a single clock domain shared with the controller top.
`timescale 1ns/1ps
`include "vic_defs.vh"

module vic_vect_mem #(
  parameter AW = 5,
  parameter DW = 32
) (
  input  wire          sys_clk,
  input  wire          clkEn,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // No reset on the array so it maps onto plain RAM; software loads it first
  reg [DW-1:0] memArr [0:(1<<AW)-1];

  always @(posedge sys_clk) begin
    if (clkEn) begin
      if (wrEn) begin
        memArr[wrAddr] <= wrData;
      end
      rdData <= memArr[rdAddr];
    end
  end

endmodule

// ---- hw/vic_vectored_int_ctrl.v ----
// Vectored interrupt controller top: classification, priority, APB registers.
// Assumes an APB master on sys_clk and request lines synchronous to sys_clk.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "vic_defs.vh"

module vic_vectored_int_ctrl #(
  parameter NUM_SRC = 32,
  parameter NUM_LVL = 16
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire [31:0] irqLines,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         fast_interrupt_request,
  output reg         normalIrq,
  output wire        ctrlIrq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [31:0]              classSel_r;
  reg  [31:0]              enable_r;
  reg  [31:0]              softInt_r;
  reg  [NUM_LVL-1:0]       prioMask_r;
  reg  [`VIC_PRIO_W-1:0]   prio_r [0:NUM_SRC-1];
  reg  [`VIC_EVT_W-1:0]    evtStat_r;
  reg  [`VIC_EVT_W-1:0]    evtEn_r;
  reg                      fastPrev_r;
  reg                      nrmPrev_r;
  reg  [4:0]               winIdx_r;
  reg                      winVld_r;

  wire [31:0]              rawReq;
  wire [31:0]              fastStat;
  wire [31:0]              nrmStat;
  wire                     apbWr;
  wire                     apbRd;
  wire                     vectHit;
  wire                     prioHit;
  wire [31:0]              vectRdData;
  reg  [31:0]              nrmLive;
  reg  [4:0]               winIdx;
  reg                      winVld;
  reg  [`VIC_PRIO_W-1:0]   winPrio;
  reg  [31:0]              rdMux;
  reg                      rdDecErr;
  wire [31:0]              curVect;
  integer                  i;
  integer                  j;
  integer                  k;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // True when an address falls in a 32-word table starting at base
  function inTable;
    input [11:0] addr;
    input [11:0] base;
    begin
      inTable = (addr[11:7] == base[11:7]) && (addr[1:0] == 2'b00);
    end
  endfunction

  // Apply a write-one-to-clear mask to a word
  function [31:0] woClear;
    input [31:0] cur;
    input [31:0] clr;
    begin
      woClear = cur & ~clr;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Request combination and classification
  // --------------------------------------------------------------------------
  assign rawReq   = irqLines | softInt_r;
  assign fastStat = rawReq & enable_r & classSel_r;
  assign nrmStat  = rawReq & enable_r & ~classSel_r;

  // Normal requests whose priority level is not masked
  always @* begin
    nrmLive = 32'h00000000;
    for (j = 0; j < NUM_SRC; j = j + 1) begin
      nrmLive[j] = nrmStat[j] & prioMask_r[prio_r[j]];
    end
  end

  // Priority search: lower level value wins; strict compare keeps lowest channel
  always @* begin
    winIdx  = 5'h00;
    winVld  = 1'b0;
    winPrio = {`VIC_PRIO_W{1'b1}};
    for (k = 0; k < NUM_SRC; k = k + 1) begin
      if (nrmLive[k] && (!winVld || (prio_r[k] < winPrio))) begin
        winVld  = 1'b1;
        winPrio = prio_r[k];
        winIdx  = k[4:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Processor interrupt outputs
  // --------------------------------------------------------------------------
  // Registered outputs cost one cycle of latency but keep the core glitch-free
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_interrupt_request <= 1'b0;
      normalIrq              <= 1'b0;
      winIdx_r               <= 5'h00;
      winVld_r               <= 1'b0;
    end else if (clkEn) begin
      fast_interrupt_request <= |fastStat;
      // Normal line is held off while any fast request is active
      normalIrq              <= winVld & ~(|fastStat);
      winIdx_r               <= winIdx;
      winVld_r               <= winVld;
    end
  end

  // --------------------------------------------------------------------------
  // Vector table
  // --------------------------------------------------------------------------
  assign vectHit = inTable(paddr, `VIC_OFF_VECT_BASE);
  assign prioHit = inTable(paddr, `VIC_OFF_PRIO_BASE);

  vic_vect_mem #(
    .AW (5),
    .DW (32)
  ) uVectMem (
    .sys_clk (sys_clk),
    .clkEn   (clkEn),
    .wrEn    (apbWr & vectHit),
    .wrAddr  (paddr[6:2]),
    .wrData  (pwdata),
    .rdAddr  (winIdx),
    .rdData  (vectRdData)
  );

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign apbWr   = psel & penable & pwrite & clkEn;
  assign apbRd   = psel & penable & ~pwrite & clkEn;
  assign pslverr = psel & penable & rdDecErr;

  // Register writes; class, enable and priority steer the logic the next cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      classSel_r <= `VIC_RST_WORD;
      enable_r   <= `VIC_RST_WORD;
      softInt_r  <= `VIC_RST_WORD;
      prioMask_r <= `VIC_RST_PRIO_MASK;
      evtEn_r    <= {`VIC_EVT_W{1'b0}};
      for (i = 0; i < NUM_SRC; i = i + 1) begin
        prio_r[i] <= `VIC_RST_PRIO;
      end
    end else if (apbWr) begin
      case (paddr)
        `VIC_OFF_CLASS_SEL: classSel_r <= pwdata;
        `VIC_OFF_EN_SET:    enable_r   <= enable_r | pwdata;
        `VIC_OFF_EN_CLR:    enable_r   <= woClear(enable_r, pwdata);
        `VIC_OFF_SW_SET:    softInt_r  <= softInt_r | pwdata;
        `VIC_OFF_SW_CLR:    softInt_r  <= woClear(softInt_r, pwdata);
        `VIC_OFF_PRIO_MASK: prioMask_r <= pwdata[NUM_LVL-1:0];
        `VIC_OFF_EVT_EN:    evtEn_r    <= pwdata[`VIC_EVT_W-1:0];
        default: begin
          if (prioHit) begin
            prio_r[paddr[6:2]] <= pwdata[`VIC_PRIO_W-1:0];
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Event status: rising edges of each output, sticky until cleared
  // --------------------------------------------------------------------------
  wire [`VIC_EVT_W-1:0] evtSet;
  wire [`VIC_EVT_W-1:0] evtClr;
  assign evtSet[`VIC_EVT_FST_BIT] = fast_interrupt_request & ~fastPrev_r;
  assign evtSet[`VIC_EVT_NRM_BIT] = normalIrq & ~nrmPrev_r;
  assign evtClr = (apbWr && paddr == `VIC_OFF_EVT_CLR) ? pwdata[`VIC_EVT_W-1:0]
                                                       : {`VIC_EVT_W{1'b0}};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evtStat_r  <= {`VIC_EVT_W{1'b0}};
      fastPrev_r <= 1'b0;
      nrmPrev_r  <= 1'b0;
    end else if (clkEn) begin
      // A set in the same cycle as a clear wins, so no edge is lost
      evtStat_r  <= (evtStat_r & ~evtClr) | evtSet;
      fastPrev_r <= fast_interrupt_request;
      nrmPrev_r  <= normalIrq;
    end
  end

  assign ctrlIrq = |(evtStat_r & evtEn_r);

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always @* begin
    rdMux     = 32'h00000000;
    rdDecErr  = 1'b0;
    case (paddr)
      `VIC_OFF_NRM_STAT:  rdMux = nrmStat;
      `VIC_OFF_FST_STAT:  rdMux = fastStat;
      `VIC_OFF_RAW_STAT:  rdMux = rawReq;
      `VIC_OFF_CLASS_SEL: rdMux = classSel_r;
      `VIC_OFF_EN_SET:    rdMux = enable_r;
      `VIC_OFF_SW_SET:    rdMux = softInt_r;
      `VIC_OFF_PRIO_MASK: rdMux = {{(32-NUM_LVL){1'b0}}, prioMask_r};
      `VIC_OFF_CUR_VECT:  rdMux = curVect;
      `VIC_OFF_EVT_STAT:  rdMux = {{(32-`VIC_EVT_W){1'b0}}, evtStat_r};
      `VIC_OFF_EVT_EN:    rdMux = {{(32-`VIC_EVT_W){1'b0}}, evtEn_r};
      `VIC_OFF_EN_CLR:    rdMux = 32'h00000000;
      `VIC_OFF_SW_CLR:    rdMux = 32'h00000000;
      `VIC_OFF_EVT_CLR:   rdMux = 32'h00000000;
      default: begin
        if (prioHit) begin
          rdMux = {{(32-`VIC_PRIO_W){1'b0}}, prio_r[paddr[6:2]]};
        end else if (!vectHit) begin
          rdDecErr = 1'b1;
        end
      end
    endcase
  end

  // Data out registered on the setup edge so it stands through the access cycle.
  // Vector table entries read back as zero: the table's port serves the winner.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (clkEn && psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end

  // Current vector: zero when no normal request wins
  assign curVect = winVld_r ? vectRdData : 32'h00000000;

endmodule

// ---- testbench/vic_ctrl_chk.sv ----
// Port checker for the vectored interrupt controller.
// Assumes one clock, async active-low reset, bound to the top.
`timescale 1ns/1ps
module vic_ctrl_chk (
  input wire        sys_clk,
  input wire        rst_n,
  input wire [31:0] irqLines,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        fast_interrupt_request,
  input wire        normalIrq
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire busAcc = psel && penable;
  wire busWr  = busAcc && pwrite;
  property p_fastCause;
    $rose(fast_interrupt_request) |-> $past(irqLines != 32'h0 || busWr);
  endproperty
  a_fastCause: assert property (p_fastCause) else $error("fast rose unprompted");
  property p_normCause;
    $rose(normalIrq) |-> $past(irqLines != 32'h0 || busWr || fast_interrupt_request);
  endproperty
  a_normCause: assert property (p_normCause) else $error("normal rose unprompted");
  property p_fastWins;
    fast_interrupt_request |-> !normalIrq;
  endproperty
  a_fastWins: assert property (p_fastWins) else $error("normal beside fast");
  // Outputs only move on request edges or register writes
  property p_hold;
    (!busWr && $stable(irqLines)) [*3] |-> $stable(fast_interrupt_request) && $stable(normalIrq);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved alone");
  // A write lands at its access edge, so the output moves one edge later and its fall is sampled two edges on
  property p_fastDrop;
    $fell(fast_interrupt_request) |-> $past(busWr, 2) || $past(irqLines) != $past(irqLines, 2);
  endproperty
  a_fastDrop: assert property (p_fastDrop) else $error("fast fell unprompted");
  property p_unmapErr;
    busAcc && paddr == 12'h020 |-> pslverr && pready;
  endproperty
  a_unmapErr: assert property (p_unmapErr) else $error("no error on hole");
  property p_errInAcc;
    pslverr |-> busAcc;
  endproperty
  a_errInAcc: assert property (p_errInAcc) else $error("stray error");
  property p_statusOk;
    busAcc && (paddr == 12'h000 || paddr == 12'h004) |-> !pslverr;
  endproperty
  a_statusOk: assert property (p_statusOk) else $error("status refused");
  c_fast: cover property ($rose(fast_interrupt_request));
  c_norm: cover property ($rose(normalIrq));
  c_err: cover property (pslverr);
endmodule
bind vic_vectored_int_ctrl vic_ctrl_chk u_vic_ctrl_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .irqLines(irqLines), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .fast_interrupt_request(fast_interrupt_request),
  .normalIrq(normalIrq)
);

// ---- testbench/vic_core_model.sv ----
// Core-side model: picks which request the processor would take.
// Assumes registered level requests on sys_clk.
`timescale 1ns/1ps
module vic_core_model (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       fastReq,
  input  wire       normalReq,
  output reg  [1:0] mode
);
  // Fast entry preempts normal, as a real core would
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      mode <= 2'h0;
    else
      mode <= fastReq ? 2'h2 : (normalReq ? 2'h1 : 2'h0);
  end
endmodule

// ---- testbench/vic_vectored_int_ctrl_tb.sv ----
// Self-checking bench: APB tasks, request lines and a core model.
// Assumes the zero-wait APB slave and one-edge output latency.
`timescale 1ns/1ps
module vic_vectored_int_ctrl_tb;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [31:0] irqLines = 32'h0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h0;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready, pslverr, fastReq, normalIrq, ctrlIrq;
  wire [1:0]  coreMode;
  integer     failures = 0;
  integer     compares = 0;
  always #5 sys_clk = ~sys_clk;
  vic_vectored_int_ctrl u_vic_vectored_int_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(1'b1), .irqLines(irqLines), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_interrupt_request(fastReq), .normalIrq(normalIrq), .ctrlIrq(ctrlIrq));
  vic_core_model u_vic_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .fastReq(fastReq),
    .normalReq(normalIrq), .mode(coreMode));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (n == 20) begin
        failures = failures + 1;
        report_and_stop;
      end
      rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  // Waits past the one-edge latency, so the value has landed
  task outs(input [2:0] exp);
    begin
      repeat (3) @(posedge sys_clk);
      chk({29'h0, ctrlIrq, normalIrq, fastReq}, {29'h0, exp});
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    outs(3'h0);
    rdc(12'h024, 32'h0000ffff);
    rdc(12'h200, 32'h0000000f);
    rdc(12'h00c, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    wr(12'h00c, 32'h8);
    wr(12'h010, 32'h88);
    wr(12'h034, 32'h3);
    irqLines <= 32'h88;
    outs(3'h5);
    chk({30'h0, coreMode}, 32'h2);
    rdc(12'h004, 32'h8);
    rdc(12'h000, 32'h80);
    irqLines <= 32'h80;
    outs(3'h6);
    wr(12'h030, 32'h3);
    outs(3'h2);
    $display("test classes done");
    wr(12'h014, 32'h80);
    outs(3'h0);
    rdc(12'h008, 32'h80);
    rdc(12'h000, 32'h0);
    wr(12'h034, 32'h0);
    wr(12'h010, 32'h200);
    wr(12'h018, 32'h200);
    outs(3'h2);
    rdc(12'h008, 32'h280);
    wr(12'h224, 32'h5);
    wr(12'h024, 32'hffdf);
    outs(3'h0);
    wr(12'h024, 32'hffff);
    outs(3'h2);
    wr(12'h00c, 32'h208);
    outs(3'h1);
    rdc(12'h02c, 32'h3);
    wr(12'h01c, 32'h200);
    outs(3'h0);
    $display("test soft and mask done");
    wr(12'h11c, 32'h00007000);
    wr(12'h124, 32'h00009000);
    wr(12'h00c, 32'h0);
    wr(12'h010, 32'h80);
    wr(12'h018, 32'h200);
    rdc(12'h028, 32'h00009000);
    wr(12'h21c, 32'h5);
    rdc(12'h028, 32'h00007000);
    wr(12'h024, 32'hffdf);
    rdc(12'h028, 32'h0);
    $display("test vector done");
    report_and_stop;
  end
endmodule
